//--- rtl/ccpu_pkg.sv
package ccpu_pkg;
  // Register byte addresses on the bus
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_TIMER_SEL = 12'h004;
  localparam logic [11:0] ADDR_VALUE_LOW = 12'h008;
  localparam logic [11:0] ADDR_VALUE_HIGH = 12'h00C;
  localparam logic [11:0] ADDR_CAP_SRC = 12'h010;
  // Control fields
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_FMT_BIT = 4;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] TSEL_RESET = 8'h00;
  localparam logic [7:0] VAL_RESET = 8'h00;
  localparam logic [2:0] CAP_RESET = 3'h0;
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOG_CLR = 4'h1;
  localparam logic [3:0] MODE_CMP_TOG = 4'h2;
  localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_PULSE = 4'hA;
  localparam logic [3:0] MODE_CMP_PULSE_CLR = 4'hB;
  // Prescale counts for capture
  localparam logic [3:0] PRE_RISE4 = 4'h3;
  localparam logic [3:0] PRE_RISE16 = 4'hF;
endpackage

//--- rtl/ccpu_unit.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ccpu_unit (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] SIXTEEN_BIT_TIMER,
  input wire logic [2:0] PERIOD_TIMER_TICK,
  input wire logic [2:0] PERIOD_TIMER_MATCH,
  input wire logic [23:0] PERIOD_TIMER_COUNT,
  input wire logic [1:0] SUB_TICK_BITS,
  input wire logic PIN_SELECT_INPUT,
  input wire logic [3:0] COMPARATOR_SYNCED,
  input wire logic LOGIC_CELL_TWO,
  input wire logic LOGIC_CELL_THREE,
  input wire logic PIN_CHANGE_EVENT,
  output logic UNIT_OUT,
  output logic UNIT_OUT_OE,
  output logic TIMER_CLEAR,
  output logic [7:0] TIMER_SELECT
);
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] tsel_r, tsel_nxt;
  logic [7:0] vlo_r, vlo_nxt;
  logic [7:0] vhi_r, vhi_nxt;
  logic [2:0] cap_r, cap_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic clr_r, clr_nxt;
  logic pulse_r, pulse_nxt;
  logic trig_r, trig_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [9:0] wbuf_r, wbuf_nxt;
  logic [3:0] mode_last_r, mode_last_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  logic [3:0] mode;
  logic en, fmt, is_pwm, is_cap, is_cmp, match;
  logic trig_in, rise, fall, cap_edge;
  logic [9:0] width;
  logic [9:0] time_base;
  logic [7:0] tcount;
  logic ptick, pmatch;
  logic wr, rd_sel;
  logic [1:0] csel;

  assign mode = ctl_r[3:0];
  assign en = ctl_r[ccpu_pkg::CTL_EN_BIT];
  assign fmt = ctl_r[ccpu_pkg::CTL_FMT_BIT];
  assign is_pwm = en && (mode[3:2] == 2'b11);
  assign is_cap = en && (mode >= ccpu_pkg::MODE_CAP_BOTH) && (mode <= ccpu_pkg::MODE_CAP_RISE16);
  assign is_cmp = en && !is_pwm && !is_cap && (mode != ccpu_pkg::MODE_OFF);
  assign match = (SIXTEEN_BIT_TIMER == {vhi_r, vlo_r});
  assign csel = tsel_r[1:0];
  assign TIMER_SELECT = tsel_r;

  // Width alignment
  always_comb begin
    if (fmt) begin
      width = {vhi_r, vlo_r[7:6]};
    end else begin
      width = {vhi_r[1:0], vlo_r};
    end
  end

  // Period timer pick for this channel
  always_comb begin
    case (csel)
      2'b00: begin
        tcount = PERIOD_TIMER_COUNT[7:0];
        ptick = PERIOD_TIMER_TICK[0];
        pmatch = PERIOD_TIMER_MATCH[0];
      end
      2'b01: begin
        tcount = PERIOD_TIMER_COUNT[15:8];
        ptick = PERIOD_TIMER_TICK[1];
        pmatch = PERIOD_TIMER_MATCH[1];
      end
      2'b10: begin
        tcount = PERIOD_TIMER_COUNT[23:16];
        ptick = PERIOD_TIMER_TICK[2];
        pmatch = PERIOD_TIMER_MATCH[2];
      end
      default: begin
        tcount = 8'h00;
        ptick = 1'b0;
        pmatch = 1'b0;
      end
    endcase
  end
  assign time_base = {tcount, SUB_TICK_BITS};

  // Capture trigger source
  always_comb begin
    case (cap_r)
      3'h0: trig_in = PIN_SELECT_INPUT;
      3'h1: trig_in = COMPARATOR_SYNCED[0];
      3'h2: trig_in = COMPARATOR_SYNCED[1];
      3'h3: trig_in = COMPARATOR_SYNCED[2];
      3'h4: trig_in = COMPARATOR_SYNCED[3];
      3'h5: trig_in = LOGIC_CELL_TWO;
      3'h6: trig_in = LOGIC_CELL_THREE;
      default: trig_in = PIN_CHANGE_EVENT;
    endcase
  end
  assign rise = trig_in && !trig_r;
  assign fall = !trig_in && trig_r;

  always_comb begin
    cap_edge = 1'b0;
    pre_nxt = pre_r;
    trig_nxt = trig_in;
    if (is_cap) begin
      case (mode)
        ccpu_pkg::MODE_CAP_BOTH: cap_edge = rise || fall;
        ccpu_pkg::MODE_CAP_FALL: cap_edge = fall;
        ccpu_pkg::MODE_CAP_RISE: cap_edge = rise;
        ccpu_pkg::MODE_CAP_RISE4: begin
          if (rise) begin
            cap_edge = (pre_r[1:0] == ccpu_pkg::PRE_RISE4[1:0]);
            pre_nxt = pre_r + 4'h1;
          end
        end
        ccpu_pkg::MODE_CAP_RISE16: begin
          if (rise) begin
            cap_edge = (pre_r == ccpu_pkg::PRE_RISE16);
            pre_nxt = pre_r + 4'h1;
          end
        end
        default: cap_edge = 1'b0;
      endcase
    end else begin
      pre_nxt = 4'h0;
    end
  end

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd_sel = PSEL && !PENABLE;

  // Register writes and captures
  always_comb begin
    ctl_nxt = ctl_r;
    tsel_nxt = tsel_r;
    vlo_nxt = vlo_r;
    vhi_nxt = vhi_r;
    cap_nxt = cap_r;
    if (cap_edge) begin
      vlo_nxt = SIXTEEN_BIT_TIMER[7:0];
      vhi_nxt = SIXTEEN_BIT_TIMER[15:8];
    end
    if (wr) begin
      case (PADDR)
        ccpu_pkg::ADDR_CONTROL: ctl_nxt = {PWDATA[7], 2'b00, PWDATA[4:0]};
        ccpu_pkg::ADDR_TIMER_SEL: tsel_nxt = PWDATA[7:0];
        ccpu_pkg::ADDR_VALUE_LOW: vlo_nxt = PWDATA[7:0];
        ccpu_pkg::ADDR_VALUE_HIGH: vhi_nxt = PWDATA[7:0];
        ccpu_pkg::ADDR_CAP_SRC: cap_nxt = PWDATA[2:0];
        default: ctl_nxt = ctl_r;
      endcase
    end
  end

  // Output generation
  always_comb begin
    out_nxt = out_r;
    clr_nxt = 1'b0;
    pulse_nxt = 1'b0;
    wbuf_nxt = wbuf_r;
    mode_last_nxt = en ? mode : ccpu_pkg::MODE_OFF;
    oe_nxt = en && !is_cap && (mode != ccpu_pkg::MODE_OFF);
    if (!en || mode == ccpu_pkg::MODE_OFF) begin
      out_nxt = 1'b0;
      wbuf_nxt = 10'h000;
    end else if (is_pwm) begin
      if (ptick && pmatch) begin
        wbuf_nxt = width;
        out_nxt = (width != 10'h000);
      end else if (time_base == wbuf_r) begin
        out_nxt = 1'b0;
      end
    end else if (is_cmp) begin
      case (mode)
        ccpu_pkg::MODE_CMP_TOG_CLR: begin
          if (match) begin
            out_nxt = !out_r;
            clr_nxt = 1'b1;
          end
        end
        ccpu_pkg::MODE_CMP_TOG: begin
          if (match) out_nxt = !out_r;
        end
        ccpu_pkg::MODE_CMP_SET: begin
          if (match) out_nxt = 1'b1;
        end
        ccpu_pkg::MODE_CMP_CLR: begin
          if (mode_last_r != mode) out_nxt = 1'b1;
          else if (match) out_nxt = 1'b0;
        end
        ccpu_pkg::MODE_CMP_PULSE: begin
          out_nxt = match;
          pulse_nxt = match;
        end
        ccpu_pkg::MODE_CMP_PULSE_CLR: begin
          out_nxt = match;
          clr_nxt = match;
        end
        default: out_nxt = out_r;
      endcase
    end
  end

  // APB slave, zero wait states
  always_comb begin
    pready_nxt = rd_sel;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (rd_sel) begin
      case (PADDR)
        ccpu_pkg::ADDR_CONTROL: begin
          prdata_nxt = {24'h000000, ctl_r[7], 1'b0, out_r, ctl_r[4:0]};
        end
        ccpu_pkg::ADDR_TIMER_SEL: prdata_nxt = {24'h000000, tsel_r};
        ccpu_pkg::ADDR_VALUE_LOW: prdata_nxt = {24'h000000, vlo_r};
        ccpu_pkg::ADDR_VALUE_HIGH: prdata_nxt = {24'h000000, vhi_r};
        ccpu_pkg::ADDR_CAP_SRC: prdata_nxt = {29'h00000000, cap_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctl_r <= ccpu_pkg::CTL_RESET;
      tsel_r <= ccpu_pkg::TSEL_RESET;
      vlo_r <= ccpu_pkg::VAL_RESET;
      vhi_r <= ccpu_pkg::VAL_RESET;
      cap_r <= ccpu_pkg::CAP_RESET;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      clr_r <= 1'b0;
      pulse_r <= 1'b0;
      trig_r <= 1'b0;
      pre_r <= 4'h0;
      wbuf_r <= 10'h000;
      mode_last_r <= ccpu_pkg::MODE_OFF;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      tsel_r <= tsel_nxt;
      vlo_r <= vlo_nxt;
      vhi_r <= vhi_nxt;
      cap_r <= cap_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      clr_r <= clr_nxt;
      pulse_r <= pulse_nxt;
      trig_r <= trig_nxt;
      pre_r <= pre_nxt;
      wbuf_r <= wbuf_nxt;
      mode_last_r <= mode_last_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign UNIT_OUT = out_r;
  assign UNIT_OUT_OE = oe_r;
  assign TIMER_CLEAR = clr_r;
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;

  property p_reset_clears;
    @(posedge MCLK) SRST |=> (ctl_r == 8'h00 && !UNIT_OUT_OE && !UNIT_OUT);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset state wrong");

  property p_off_low;
    @(posedge MCLK) disable iff (SRST) (!en) |=> !UNIT_OUT;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output high while off");

  property p_out_bit_ro;
    @(posedge MCLK) disable iff (SRST) wr && PADDR == ccpu_pkg::ADDR_CONTROL |=> !ctl_r[5];
  endproperty
  a_out_bit_ro: assert property (p_out_bit_ro) else $error("out bit stored");

  property p_clr_pulse;
    @(posedge MCLK) disable iff (SRST)
      is_cmp && mode == ccpu_pkg::MODE_CMP_PULSE_CLR && match |=> TIMER_CLEAR && UNIT_OUT;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("no pulse with clear");

  property p_toggle;
    @(posedge MCLK) disable iff (SRST)
      is_cmp && mode == ccpu_pkg::MODE_CMP_TOG && match && !wr |=> UNIT_OUT != $past(UNIT_OUT);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match");

  property p_capture;
    @(posedge MCLK) disable iff (SRST)
      cap_edge && !wr |=> {vhi_r, vlo_r} == $past(SIXTEEN_BIT_TIMER);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_pwm_set;
    @(posedge MCLK) disable iff (SRST)
      is_pwm && ptick && pmatch && width != 10'h000 |=> UNIT_OUT && wbuf_r == $past(width);
  endproperty
  a_pwm_set: assert property (p_pwm_set) else $error("period start wrong");

  property p_pwm_clear;
    @(posedge MCLK) disable iff (SRST)
      is_pwm && !(ptick && pmatch) && time_base == wbuf_r |=> !UNIT_OUT;
  endproperty
  a_pwm_clear: assert property (p_pwm_clear) else $error("width end missed");
endmodule // ccpu_unit
`default_nettype wire

//--- verif/ccpu_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccpu_far_model #(
  parameter logic [7:0] LIMIT = 8'h07
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic RUN,
  input wire logic TIMER_CLEAR,
  output logic [15:0] TIMER16,
  output logic [2:0] TICK,
  output logic [2:0] MATCH,
  output logic [23:0] COUNT,
  output logic [1:0] SUB
);
  logic [1:0] sub_r;
  logic [7:0] cnt_r;
  logic [15:0] t16_r;
  // Period timers step once every four clocks
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sub_r <= 2'h0;
      cnt_r <= 8'h00;
      t16_r <= 16'h0000;
    end else begin
      sub_r <= sub_r + 2'h1;
      if (sub_r == 2'h3) cnt_r <= (cnt_r == LIMIT) ? 8'h00 : cnt_r + 8'h01;
      if (TIMER_CLEAR || !RUN) t16_r <= 16'h0000;
      else t16_r <= t16_r + 16'h0001;
    end
  end
  assign SUB = sub_r;
  assign TICK = {3{sub_r == 2'h3}};
  assign MATCH = {3{cnt_r == LIMIT}};
  assign COUNT = {3{cnt_r}};
  assign TIMER16 = t16_r;
endmodule // ccpu_far_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, q;
  logic PREADY, PSLVERR, e, UNIT_OUT, UNIT_OUT_OE, TIMER_CLEAR;
  logic run = 1'b0;
  logic pin = 1'b0;
  logic lc2 = 1'b0;
  logic lc3 = 1'b0;
  logic chg = 1'b0;
  logic [3:0] cmp = 4'h0;
  logic [15:0] fix = 16'h0000;
  logic [15:0] t16;
  logic [2:0] tick, mat;
  logic [23:0] pcnt;
  logic [1:0] sub;
  logic [7:0] tsel;
  int num_errors = 0;
  int tests_run = 0;
  int a, b, c;
  always #5 MCLK = ~MCLK;
  ccpu_unit uut (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SIXTEEN_BIT_TIMER(run ? t16 : fix), .PERIOD_TIMER_TICK(tick), .PERIOD_TIMER_MATCH(mat),
    .PERIOD_TIMER_COUNT(pcnt), .SUB_TICK_BITS(sub), .PIN_SELECT_INPUT(pin),
    .COMPARATOR_SYNCED(cmp), .LOGIC_CELL_TWO(lc2), .LOGIC_CELL_THREE(lc3),
    .PIN_CHANGE_EVENT(chg), .UNIT_OUT(UNIT_OUT), .UNIT_OUT_OE(UNIT_OUT_OE),
    .TIMER_CLEAR(TIMER_CLEAR), .TIMER_SELECT(tsel));
  ccpu_far_model far (.MCLK(MCLK), .SRST(SRST), .RUN(run), .TIMER_CLEAR(TIMER_CLEAR),
    .TIMER16(t16), .TICK(tick), .MATCH(mat), .COUNT(pcnt), .SUB(sub));
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    q = PRDATA;
    e = PSLVERR;
    if (n >= 20) begin
      check("bus wait", 0, 1);
      summarize();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] exp, input string what);
    apb(1'b0, ad, 32'h0);
    check(what, q, exp);
  endtask
  task automatic wait_out(input logic lvl, input int bound);
    int n;
    n = 0;
    while (UNIT_OUT !== lvl && n < bound) begin
      @(posedge MCLK);
      n++;
    end
    check("output level", UNIT_OUT, lvl);
    if (n >= bound) summarize();
  endtask
  task automatic pulse(input logic on_cmp);
    @(posedge MCLK);
    if (on_cmp) cmp[0] <= 1'b1;
    else pin <= 1'b1;
    repeat (3) @(posedge MCLK);
    cmp[0] <= 1'b0;
    pin <= 1'b0;
    repeat (3) @(posedge MCLK);
  endtask
  task automatic t_reset;
    rd(ccpu_pkg::ADDR_CONTROL, 32'h0, "control");
    rd(ccpu_pkg::ADDR_TIMER_SEL, 32'h0, "timer select");
    rd(ccpu_pkg::ADDR_VALUE_LOW, 32'h0, "low byte");
    rd(ccpu_pkg::ADDR_VALUE_HIGH, 32'h0, "high byte");
    rd(ccpu_pkg::ADDR_CAP_SRC, 32'h0, "capture select");
    check("pin enable", UNIT_OUT_OE, 1'b0);
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped error", e, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr(ccpu_pkg::ADDR_CONTROL, 32'hE0);
    rd(ccpu_pkg::ADDR_CONTROL, 32'h80, "control");
    wr(ccpu_pkg::ADDR_TIMER_SEL, 32'hA5);
    rd(ccpu_pkg::ADDR_TIMER_SEL, 32'hA5, "timer select");
    check("timer select pins", tsel, 8'hA5);
    wr(ccpu_pkg::ADDR_CAP_SRC, 32'hFF);
    rd(ccpu_pkg::ADDR_CAP_SRC, 32'h07, "capture select");
    wr(ccpu_pkg::ADDR_TIMER_SEL, 32'h0);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    $display("register test done");
  endtask
  task automatic t_compare;
    int n;
    n = 0;
    wr(ccpu_pkg::ADDR_VALUE_HIGH, 32'h01);
    wr(ccpu_pkg::ADDR_VALUE_LOW, 32'h05);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h81);
    run <= 1'b1;
    while (TIMER_CLEAR !== 1'b1 && n < 400) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 400) begin
      check("clear timeout", 0, 1);
      summarize();
    end
    check("match not early", n > 250, 1'b1);
    check("toggle high", UNIT_OUT, 1'b1);
    wait_out(1'b0, 400);
    run <= 1'b0;
    wr(ccpu_pkg::ADDR_CONTROL, 32'h89);
    repeat (2) @(posedge MCLK);
    check("set on entry", UNIT_OUT, 1'b1);
    rd(ccpu_pkg::ADDR_CONTROL, 32'hA9, "control");
    run <= 1'b1;
    wait_out(1'b0, 400);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    run <= 1'b0;
    $display("compare test done");
  endtask
  task automatic t_capture;
    fix <= 16'h1234;
    wr(ccpu_pkg::ADDR_CAP_SRC, 32'h0);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h85);
    pulse(1'b0);
    rd(ccpu_pkg::ADDR_VALUE_LOW, 32'h34, "low byte");
    rd(ccpu_pkg::ADDR_VALUE_HIGH, 32'h12, "high byte");
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    wr(ccpu_pkg::ADDR_VALUE_LOW, 32'h0);
    wr(ccpu_pkg::ADDR_CAP_SRC, 32'h1);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h86);
    fix <= 16'h5A3C;
    repeat (3) pulse(1'b1);
    rd(ccpu_pkg::ADDR_VALUE_LOW, 32'h0, "low byte");
    pulse(1'b1);
    rd(ccpu_pkg::ADDR_VALUE_LOW, 32'h3C, "low byte");
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    wr(ccpu_pkg::ADDR_CAP_SRC, 32'h0);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h84);
    fix <= 16'h00C3;
    check("capture pin enable", UNIT_OUT_OE, 1'b0);
    pulse(1'b0);
    rd(ccpu_pkg::ADDR_VALUE_LOW, 32'hC3, "low byte fall");
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    $display("capture test done");
  endtask
  task automatic t_cmp_more;
    int n;
    n = 0;
    wr(ccpu_pkg::ADDR_VALUE_HIGH, 32'h00);
    wr(ccpu_pkg::ADDR_VALUE_LOW, 32'h05);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h8B);
    run <= 1'b1;
    while (TIMER_CLEAR !== 1'b1 && n < 50) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 50) begin
      check("pulse clear timeout", 0, 1);
      summarize();
    end
    check("pulse high", UNIT_OUT, 1'b1);
    @(posedge MCLK);
    check("pulse low", UNIT_OUT, 1'b0);
    run <= 1'b0;
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h88);
    check("set mode start", UNIT_OUT, 1'b0);
    run <= 1'b1;
    wait_out(1'b1, 50);
    run <= 1'b0;
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    $display("compare modes test done");
  endtask
  task automatic pwm_len(input logic [7:0] ctl, input logic [7:0] lo, input logic [7:0] hi,
      output int len);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    wr(ccpu_pkg::ADDR_VALUE_LOW, {24'h0, lo});
    wr(ccpu_pkg::ADDR_VALUE_HIGH, {24'h0, hi});
    wr(ccpu_pkg::ADDR_CONTROL, {24'h0, ctl});
    wait_out(1'b1, 200);
    len = 0;
    check("pwm pin enable", UNIT_OUT_OE, 1'b1);
    while (UNIT_OUT === 1'b1 && len < 100) begin
      @(posedge MCLK);
      len++;
    end
    if (len >= 100) begin
      check("pwm stuck high", 0, 1);
      summarize();
    end
  endtask
  task automatic t_pwm;
    pwm_len(8'h8C, 8'h0A, 8'hFC, a);
    pwm_len(8'h9C, 8'hBF, 8'h02, b);
    pwm_len(8'h8F, 8'h14, 8'h00, c);
    check("aligned width", b, a);
    check("width step", c - a, 10);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h0);
    wr(ccpu_pkg::ADDR_VALUE_LOW, 32'h0);
    wr(ccpu_pkg::ADDR_CONTROL, 32'h8C);
    a = 0;
    repeat (80) begin
      @(posedge MCLK);
      if (UNIT_OUT !== 1'b0) a++;
    end
    check("zero duty high", a, 0);
    $display("pulse test done");
  endtask
  initial begin
    repeat (100000) @(posedge MCLK);
    check("run time", 0, 1);
    summarize();
  end
  initial begin
    repeat (3) @(posedge MCLK);
    SRST <= 1'b0;
    t_reset();
    t_regs();
    t_compare();
    t_capture();
    t_cmp_more();
    t_pwm();
    summarize();
  end
endmodule // testbench
`default_nettype wire
